/* design/pls_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  loop lock status and event block.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PLS_OFF_STATUS 6'h00
`define PLS_OFF_EVENTS 6'h04
`define PLS_OFF_COUNTER 6'h08
`define PLS_OFF_CONFIG 6'h0c
`define PLS_OFF_IRQMASK 6'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PLS_BIT_LOCK 0
`define PLS_BIT_RAIL_LOW 1
`define PLS_BIT_RAIL_HIGH 2
`define PLS_BIT_LOL 0
`define PLS_CFG_TIMER_LSB 0
`define PLS_CFG_LATCH_BIT 2
`define PLS_CFG_DISABLE_BIT 3

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define PLS_RST_EVENTS 3'h0
`define PLS_RST_COUNTER 4'h0
`define PLS_RST_TIMER 2'h2
`define PLS_RST_MASK 3'h0
`define PLS_CNT_MAX 4'hf

// ----------------------------------------------------------------------
// Debounce intervals in system clock cycles
// ----------------------------------------------------------------------
`define PLS_DEB_CYC_1 570
`define PLS_DEB_CYC_2 5700
`define PLS_DEB_CYC_3 57000

`endif

/* design/pls_pkg.sv */
/*
  Types shared by the loop lock status and event block.
  Assumes pls_regs.svh carries all numeric constants.
*/
package pls_pkg;

  // Raw indications from the analog lock detector
  typedef struct packed {
    logic locked;
    logic railHigh;
    logic railLow;
  } pls_det_s;

  // Software configuration
  typedef struct packed {
    logic [1:0] timerSel;
    logic latchFirstLock;
    logic detDisable;
  } pls_cfg_s;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pls_wbreq_s;

  // Bus slave states
  typedef enum logic [1:0] {
    PLS_BUS_IDLE = 2'b01,
    PLS_BUS_ACK = 2'b10
  } pls_bus_e;

endpackage

/* design/pls_debounce.sv */
/*
  Lock debounce: for timerSel 1 to 3 the filtered lock follows the raw lock only
  after the raw level has held steady for the selected interval; 0 passes it through.
  Assumes raw lock is synchronous to clk.
*/
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_debounce #(
  parameter int CYC1 = `PLS_DEB_CYC_1,
  parameter int CYC2 = `PLS_DEB_CYC_2,
  parameter int CYC3 = `PLS_DEB_CYC_3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rawLock,
  input wire logic [1:0] timerSel,
  output logic lockOut
);
  import pls_pkg::*;

  localparam int CW = $clog2(CYC3 + 1);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Refused at elaboration: the compare below needs ascending limits
  if (CYC1 < 1 || CYC2 < CYC1 || CYC3 < CYC2) begin : gBadCyc
    $error("pls_debounce: intervals must be positive and ascending");
  end

  typedef struct packed {
    logic lock;
    logic [CW-1:0] cnt;
  } pls_deb_s;

  pls_deb_s st_q, st_d;
  logic [CW-1:0] limit;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Counter restarts on every raw change, so glitches never pass when timerSel is nonzero
  always_comb begin
    st_d = st_q;
    case (timerSel)
      2'd1: limit = CW'(CYC1);
      2'd2: limit = CW'(CYC2);
      2'd3: limit = CW'(CYC3);
      default: limit = '0;
    endcase
    if (timerSel == 2'd0) begin
      st_d.lock = rawLock; // No debounce selected
      st_d.cnt = '0;
    end else if (rawLock == st_q.lock) begin
      st_d.cnt = '0;
    end else if (st_q.cnt + CW'(1) >= limit) begin
      st_d.lock = rawLock;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lockOut = st_q.lock;

endmodule

/* design/pls_w1c_flag.sv */
/*
  One sticky event flag, set by hardware, cleared by writing one.
  Assumes set and clear are single-cycle qualified strobes.
*/
`timescale 1ns/1ps

module pls_w1c_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic setEvt,
  input wire logic clrEvt,
  output logic flag
);
  import pls_pkg::*;

  typedef struct packed {
    logic flag;
  } pls_flag_s;

  pls_flag_s st_q, st_d;

  // Set wins over clear so a same-cycle event is never lost
  always_comb begin
    st_d = st_q;
    if (setEvt) begin
      st_d.flag = 1'b1;
    end else if (clrEvt) begin
      st_d.flag = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag;

endmodule

/* design/pls_lock_status.sv */
/*
  Loop lock status and event register bank on a classic Wishbone slave:
  live status, sticky events, saturating loss-of-lock counter, config,
  interrupt mask and one level interrupt.
  Assumes detector inputs synchronous to clk and a 40 MHz clock.
*/
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_lock_status #(
  parameter int DEB_CYC_1 = `PLS_DEB_CYC_1,
  parameter int DEB_CYC_2 = `PLS_DEB_CYC_2,
  parameter int DEB_CYC_3 = `PLS_DEB_CYC_3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pls_pkg::pls_wbreq_s wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire pls_pkg::pls_det_s detIn,
  output logic lockInd,
  output logic irq
);
  import pls_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pls_bus_e bus;
    logic ack;
    logic [31:0] dat;
    logic [3:0] cnt;
    pls_cfg_s cfg;
    logic [2:0] mask;
    logic latched;
    logic lockPrev;
    logic lockInd;
    logic irq;
    logic [2:0] live;
  } pls_state_s;

  pls_state_s st_q, st_d;
  logic debLock;
  logic lockNow;
  logic lossEvt;
  logic wrStb;
  logic rdStb;
  logic [2:0] evtSet;
  logic [2:0] evtClr;
  logic [2:0] evtFlag;

  // ----------------------------------------------------------------------
  // Lock path
  // ----------------------------------------------------------------------
  pls_debounce #(
    .CYC1(DEB_CYC_1),
    .CYC2(DEB_CYC_2),
    .CYC3(DEB_CYC_3)
  ) uDebounce (
    .clk(clk),
    .rst_n(rst_n),
    .rawLock(detIn.locked),
    .timerSel(st_q.cfg.timerSel),
    .lockOut(debLock)
  );

  // Effective lock after disable and one-time latch
  always_comb begin
    if (st_q.cfg.detDisable) begin
      lockNow = 1'b1;
    end else if (st_q.cfg.latchFirstLock) begin
      lockNow = debLock | st_q.latched;
    end else begin
      lockNow = debLock;
    end
  end

  // Falling edge of the effective lock
  assign lossEvt = st_q.lockPrev & ~lockNow;

  // ----------------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------------
  // Accept only in idle so each request acts exactly once
  assign wrStb = wbReq.cyc & wbReq.stb & wbReq.we & (st_q.bus == PLS_BUS_IDLE);
  assign rdStb = wbReq.cyc & wbReq.stb & ~wbReq.we & (st_q.bus == PLS_BUS_IDLE);

  // ----------------------------------------------------------------------
  // Sticky events
  // ----------------------------------------------------------------------
  always_comb begin
    evtSet[`PLS_BIT_RAIL_HIGH] = detIn.railHigh;
    evtSet[`PLS_BIT_RAIL_LOW] = detIn.railLow;
    evtSet[`PLS_BIT_LOL] = lossEvt;
    evtClr = '0;
    if (wrStb && wbReq.adr == `PLS_OFF_EVENTS && wbReq.sel[0]) begin
      evtClr = wbReq.dat[2:0]; // Zero bits leave flags alone
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gFlag
      pls_w1c_flag uFlag (
        .clk(clk),
        .rst_n(rst_n),
        .setEvt(evtSet[gi]),
        .clrEvt(evtClr[gi]),
        .flag(evtFlag[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.lockPrev = lockNow;
    st_d.lockInd = lockNow;
    if (debLock) begin
      st_d.latched = 1'b1;
    end
    if (!st_q.cfg.latchFirstLock) begin
      st_d.latched = 1'b0; // Re-arm when latch mode is off
    end
    st_d.live[`PLS_BIT_LOCK] = lockNow;
    st_d.live[`PLS_BIT_RAIL_LOW] = detIn.railLow;
    st_d.live[`PLS_BIT_RAIL_HIGH] = detIn.railHigh;
    st_d.irq = |(evtFlag & st_q.mask);
    // Saturating count; a write in the same cycle wins, then counts on
    if (lossEvt && st_q.cnt != `PLS_CNT_MAX) begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
    st_d.ack = 1'b0;
    case (st_q.bus)
      PLS_BUS_IDLE: begin
        if (wrStb) begin
          st_d.ack = 1'b1;
          st_d.bus = PLS_BUS_ACK;
          if (wbReq.sel[0]) begin
            case (wbReq.adr)
              `PLS_OFF_COUNTER: st_d.cnt = wbReq.dat[3:0];
              `PLS_OFF_CONFIG: begin
                st_d.cfg.timerSel = wbReq.dat[`PLS_CFG_TIMER_LSB +: 2];
                st_d.cfg.latchFirstLock = wbReq.dat[`PLS_CFG_LATCH_BIT];
                st_d.cfg.detDisable = wbReq.dat[`PLS_CFG_DISABLE_BIT];
              end
              `PLS_OFF_IRQMASK: st_d.mask = wbReq.dat[2:0];
              default: st_d.mask = st_q.mask;
            endcase
          end
        end else if (rdStb) begin
          st_d.ack = 1'b1;
          st_d.bus = PLS_BUS_ACK;
          case (wbReq.adr)
            `PLS_OFF_STATUS: st_d.dat = {29'h0, st_q.live};
            `PLS_OFF_EVENTS: st_d.dat = {29'h0, evtFlag};
            `PLS_OFF_COUNTER: st_d.dat = {28'h0, st_q.cnt};
            `PLS_OFF_CONFIG: st_d.dat = {28'h0, st_q.cfg.detDisable,
              st_q.cfg.latchFirstLock, st_q.cfg.timerSel};
            `PLS_OFF_IRQMASK: st_d.dat = {29'h0, st_q.mask};
            default: st_d.dat = 32'h0; // Unmapped reads zero
          endcase
        end
      end
      PLS_BUS_ACK: begin
        st_d.bus = PLS_BUS_IDLE; // One turnaround cycle
      end
      default: begin
        st_d.bus = PLS_BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{bus: PLS_BUS_IDLE, ack: 1'b0, dat: 32'h0, cnt: `PLS_RST_COUNTER,
        cfg: '{timerSel: `PLS_RST_TIMER, latchFirstLock: 1'b0, detDisable: 1'b0},
        mask: `PLS_RST_MASK, latched: 1'b0, lockPrev: 1'b0, lockInd: 1'b0,
        irq: 1'b0, live: 3'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign wbAck = st_q.ack;
  assign wbDatO = st_q.dat;
  assign lockInd = st_q.lockInd;
  assign irq = st_q.irq;

endmodule

/* verif/pls_lock_status_props.sv */
/*
  Concurrent checks on the ports of the loop lock status block.
  Assumes one clock, synchronous active-low reset, bound to the top.
*/
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_lock_status_props #(
  parameter int DEB_CYC_1 = 2,
  parameter int DEB_CYC_2 = 4,
  parameter int DEB_CYC_3 = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pls_pkg::pls_wbreq_s wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire pls_pkg::pls_det_s detIn,
  input wire logic lockInd,
  input wire logic irq
);
  import pls_pkg::*;
  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Request seen while slave is idle
  sequence s_take;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  // Read answer for one address
  sequence s_rd(logic [5:0] a);
    wbAck && !$past(wbReq.we) && $past(wbReq.adr) == a;
  endsequence
  a_ack_after_take: assert property (s_take |=> wbAck)
    else $error("request not acknowledged");
  a_ack_one_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  a_ack_has_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  // Rail bits only judged when the input held still long enough
  a_rail_high_live: assert property (s_rd(`PLS_OFF_STATUS) ##0
    ($past(detIn.railHigh, 2) == $past(detIn.railHigh, 3))
    |-> wbDatO[2] == $past(detIn.railHigh, 2)) else $error("rail high status wrong");
  a_rail_low_live: assert property (s_rd(`PLS_OFF_STATUS) ##0
    ($past(detIn.railLow, 2) == $past(detIn.railLow, 3))
    |-> wbDatO[1] == $past(detIn.railLow, 2)) else $error("rail low status wrong");
  a_status_rsvd_zero: assert property (s_rd(`PLS_OFF_STATUS) |-> wbDatO[31:3] == 29'h0)
    else $error("status reserved bits set");
  a_event_rsvd_zero: assert property (s_rd(`PLS_OFF_EVENTS) |-> wbDatO[31:3] == 29'h0)
    else $error("event reserved bits set");
  a_count_rsvd_zero: assert property (s_rd(`PLS_OFF_COUNTER) |-> wbDatO[31:4] == 28'h0)
    else $error("counter reserved bits set");
  a_unmapped_zero: assert property (s_rd(6'h14) |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind pls_lock_status pls_lock_status_props #(.DEB_CYC_1(DEB_CYC_1), .DEB_CYC_2(DEB_CYC_2),
  .DEB_CYC_3(DEB_CYC_3)) u_props (.clk(clk), .rst_n(rst_n), .wbReq(wbReq),
  .wbDatO(wbDatO), .wbAck(wbAck), .detIn(detIn), .lockInd(lockInd), .irq(irq));

/* verif/pls_lock_status_tb.sv */
/*
  Self-checking bench for the loop lock status block.
  Assumes design sources compiled first; debounce counts shortened to 2/4/8.
*/
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_lock_status_tb;
  import pls_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pls_wbreq_s req = '0;
  pls_det_s det = '0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic lockInd;
  logic irq;
  logic [31:0] r;
  int n_errors = 0;
  int tests_run = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  pls_lock_status #(.DEB_CYC_1(2), .DEB_CYC_2(4), .DEB_CYC_3(8)) u_pls_lock_status (
    .clk(clk), .rst_n(rst_n), .wbReq(req), .wbDatO(wbDatO), .wbAck(wbAck),
    .detIn(det), .lockInd(lockInd), .irq(irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic cycle: hold until ack sampled, then one idle cycle
  task automatic wb(logic w, logic [5:0] a, logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    // A slave that never answers ends the run as a failure
    if (wbAck !== 1'b1) begin
      n_errors++;
      summarize();
    end
    r = wbDatO;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(string nm, logic [5:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask
  // Long enough for the slowest shortened debounce
  task automatic lose();
    det.locked <= 1'b1;
    tick(20);
    det.locked <= 1'b0;
    tick(20);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd("status", `PLS_OFF_STATUS, 32'h0);
    rd("events", `PLS_OFF_EVENTS, 32'h0);
    rd("counter", `PLS_OFF_COUNTER, 32'h0);
    wb(1'b1, 6'h14, 32'hff);
    rd("unmapped", 6'h14, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_live();
    wb(1'b1, `PLS_OFF_CONFIG, 32'h0);
    det.locked <= 1'b1;
    tick(4);
    rd("lock", `PLS_OFF_STATUS, 32'h1);
    det.railHigh <= 1'b1;
    tick(4);
    rd("railhi", `PLS_OFF_STATUS, 32'h5);
    det <= '{locked: 1'b1, railHigh: 1'b0, railLow: 1'b1};
    tick(4);
    rd("raillo", `PLS_OFF_STATUS, 32'h3);
    det.railLow <= 1'b0;
    rd("railev", `PLS_OFF_EVENTS, 32'h6);
    wb(1'b1, `PLS_OFF_EVENTS, 32'hf9);
    rd("zerokeep", `PLS_OFF_EVENTS, 32'h6);
    wb(1'b1, `PLS_OFF_IRQMASK, 32'h2);
    tick(2);
    chk("irqon", {31'h0, irq}, 32'h1);
    wb(1'b1, `PLS_OFF_EVENTS, 32'h2);
    rd("w1c", `PLS_OFF_EVENTS, 32'h4);
    chk("irqoff", {31'h0, irq}, 32'h0);
    wb(1'b1, `PLS_OFF_IRQMASK, 32'h0);
    det.locked <= 1'b0;
    tick(4);
    rd("lol", `PLS_OFF_EVENTS, 32'h5);
    rd("cnt1", `PLS_OFF_COUNTER, 32'h1);
    wb(1'b1, `PLS_OFF_EVENTS, 32'h7);
    rd("clear", `PLS_OFF_EVENTS, 32'h0);
  endtask
  task automatic t_count();
    wb(1'b1, `PLS_OFF_COUNTER, 32'hfe);
    rd("preset", `PLS_OFF_COUNTER, 32'he);
    lose();
    rd("cntf", `PLS_OFF_COUNTER, 32'hf);
    lose();
    rd("sat", `PLS_OFF_COUNTER, 32'hf);
    wb(1'b1, `PLS_OFF_COUNTER, 32'h0);
    rd("clr", `PLS_OFF_COUNTER, 32'h0);
    lose();
    rd("cont", `PLS_OFF_COUNTER, 32'h1);
  endtask
  // Each interval: short glitch dropped, lock late but not early
  task automatic t_deb();
    int n;
    for (int s = 1; s < 4; s++) begin
      n = 1 << s;
      wb(1'b1, `PLS_OFF_CONFIG, 32'(s));
      det.locked <= 1'b1;
      tick(n / 2);
      det.locked <= 1'b0;
      tick(n + 4);
      chk("glitch", {31'h0, lockInd}, 32'h0);
      det.locked <= 1'b1;
      tick(n - 1);
      chk("early", {31'h0, lockInd}, 32'h0);
      tick(5);
      chk("held", {31'h0, lockInd}, 32'h1);
      det.locked <= 1'b0;
      tick(n + 4);
    end
  endtask
  task automatic t_modes();
    wb(1'b1, `PLS_OFF_CONFIG, 32'h4);
    lose();
    chk("latch", {31'h0, lockInd}, 32'h1);
    wb(1'b1, `PLS_OFF_CONFIG, 32'h8);
    tick(4);
    chk("disable", {31'h0, lockInd}, 32'h1);
    wb(1'b1, `PLS_OFF_CONFIG, 32'h0);
    tick(4);
    chk("release", {31'h0, lockInd}, 32'h0);
  endtask
  // Main sequence
  initial begin
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_live();
    t_count();
    t_deb();
    t_modes();
    summarize();
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    tick(5000);
    n_errors++;
    summarize();
  end
endmodule
